/* pkg/pdc_pkg.sv */
package pdc_pkg;

  // ****************************************************************
  // Access port geometry
  // ****************************************************************
  localparam int DATA_W = 24;
  localparam int ADDR_W = 8;
  localparam int BLOCK_N = 10;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_RANGE = 8'h72;
  localparam logic [7:0] ADDR_GLOBAL = 8'h76;
  localparam logic [7:0] ADDR_DYN = 8'h77;

  // ****************************************************************
  // Reset values and writable field masks
  // ****************************************************************
  localparam logic [23:0] RANGE_RST_WORD = 24'h0000c0;
  localparam logic [3:0] RANGE_RST = 4'hc;
  localparam logic [9:0] KEEP_RST = 10'h000;
  localparam logic [9:0] DYN_RST = 10'h000;
  localparam logic [23:0] RANGE_MASK = 24'h0000f0;
  localparam logic [23:0] GLOBAL_MASK = 24'h000b7f;
  localparam logic [23:0] DYN_MASK = 24'h00037f;
  localparam logic [9:0] BLOCK_MASK = 10'h37f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RANGE_LSB = 4;
  localparam int RANGE_MSB = 7;
  localparam int GLOBAL_BIT = 11;
  localparam int BIT_REFERENCE = 0;
  localparam int BIT_THERMAL = 1;
  localparam int BIT_EMITTER = 2;
  localparam int BIT_FRONTEND = 3;
  localparam int BIT_FRONTEND_DAC = 4;
  localparam int BIT_AMB_CANCEL = 5;
  localparam int BIT_AMB_CONVERTER = 6;
  localparam int BIT_OSCILLATOR = 8;
  localparam int BIT_HOST_MASTER = 9;

  // ****************************************************************
  // Ambient cancellation range codes
  // ****************************************************************
  localparam logic [3:0] RANGE_20UA = 4'h0;
  localparam logic [3:0] RANGE_10UA = 4'h5;
  localparam logic [3:0] RANGE_33UA = 4'ha;
  localparam logic [3:0] RANGE_50UA = 4'hb;
  localparam logic [3:0] RANGE_100UA = 4'hc;
  localparam logic [3:0] RANGE_200UA = 4'he;

  function automatic logic pdc_range_ok(input logic [3:0] code);
    return (code == RANGE_20UA) || (code == RANGE_10UA) || (code == RANGE_33UA) ||
           (code == RANGE_50UA) || (code == RANGE_100UA) || (code == RANGE_200UA);
  endfunction

endpackage

/* rtl/pdc_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE_01] A 4-bit ambient cancellation range field sits at bits 7:4, resets to 12, and only codes 0, 5, 10, 11, 12 and 14 are valid.
// [RULE_02] Software writes zero to reserved fields and the device always reads them back as zero.
// [RULE_03] Bit 11 is the global sleep request: zero keeps all blocks active, one sleeps every block not kept awake.
// [RULE_04] A keep-awake bit at zero lets the global request act on its block, at one shields the block.
// [RULE_05] Bit 8 keeps the oscillator awake and bit 9 keeps the host master awake.
// [RULE_06] Bit 6 keeps the ambient converter awake.
// [RULE_07] Bit 5 keeps the ambient cancellation circuit awake.
// [RULE_08] Bit 4 keeps the front-end DAC awake and bit 3 keeps the front end awake.
// [RULE_09] Bit 2 keeps the emitter driver awake.
// [RULE_10] Bit 1 keeps the thermal sensor awake.
// [RULE_11] Bit 0 keeps the reference awake.
// [RULE_12] Each dynamic sleep bit enables dynamic sleep of its block at one, disables it at zero, in the same bit order.
// [RULE_13] Each block sleep output is high exactly when the global request is set and its keep-awake bit is clear; code lags one cycle, keeps bit 7 low.
module pdc_regs
  import pdc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  output logic [DATA_W-1:0] regRdata,
  output logic regRdValid,
  output logic [3:0] ambientCancelRange,
  output logic ambientRangeValid,
  output logic globalSleepRequest,
  output logic [BLOCK_N-1:0] keepAwake,
  output logic [BLOCK_N-1:0] blockSleep,
  output logic [BLOCK_N-1:0] dynamicSleepEn
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [3:0] rangeQ;
  logic rangeValidQ;
  logic globalQ;
  logic [BLOCK_N-1:0] keepQ;
  logic [BLOCK_N-1:0] dynQ;
  logic [BLOCK_N-1:0] sleepQ;
  logic [DATA_W-1:0] rdataQ;
  logic [DATA_W-1:0] rdataD;
  logic rdValidQ;
  logic wrRange;
  logic wrGlobal;
  logic wrDyn;

  assign wrRange = regWrEn && (regAddr == ADDR_RANGE);
  assign wrGlobal = regWrEn && (regAddr == ADDR_GLOBAL);
  assign wrDyn = regWrEn && (regAddr == ADDR_DYN);

  // Ambient range field
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rangeQ <= RANGE_RST; // [RULE_01]
    end else if (wrRange) begin
      rangeQ <= regWdata[RANGE_MSB:RANGE_LSB]; // [RULE_01]
    end
  end

  // Range code validity flag
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rangeValidQ <= 1'b1;
    end else begin
      rangeValidQ <= pdc_range_ok(rangeQ); // [RULE_01]
    end
  end

  // Global request and keep-awake bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      globalQ <= 1'b0;
      keepQ <= KEEP_RST;
    end else if (wrGlobal) begin
      globalQ <= regWdata[GLOBAL_BIT]; // [RULE_03]
      keepQ <= regWdata[BLOCK_N-1:0] & BLOCK_MASK; // [RULE_04] [RULE_02]
    end
  end

  // Dynamic sleep enables
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dynQ <= DYN_RST;
    end else if (wrDyn) begin
      dynQ <= regWdata[BLOCK_N-1:0] & BLOCK_MASK; // [RULE_12] [RULE_02]
    end
  end

  // ****************************************************************
  // Block sleep outputs
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < BLOCK_N; gi++) begin : gSleep
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          sleepQ[gi] <= 1'b0;
        end else begin
          sleepQ[gi] <= BLOCK_MASK[gi] && globalQ && !keepQ[gi]; // [RULE_13] [RULE_03] [RULE_04]
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdataD = '0;
    unique case (regAddr)
      ADDR_RANGE: begin
        rdataD[RANGE_MSB:RANGE_LSB] = rangeQ; // [RULE_02]
      end
      ADDR_GLOBAL: begin
        rdataD[GLOBAL_BIT] = globalQ;
        rdataD[BLOCK_N-1:0] = keepQ; // [RULE_02]
      end
      ADDR_DYN: begin
        rdataD[BLOCK_N-1:0] = dynQ; // [RULE_02]
      end
      default: begin
        rdataD = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdataQ <= '0;
      rdValidQ <= 1'b0;
    end else begin
      rdValidQ <= regRdEn;
      if (regRdEn) begin
        rdataQ <= rdataD;
      end
    end
  end

  assign regRdata = rdataQ;
  assign regRdValid = rdValidQ;
  assign ambientCancelRange = rangeQ;
  assign ambientRangeValid = rangeValidQ;
  assign globalSleepRequest = globalQ;
  assign keepAwake = keepQ;
  assign blockSleep = sleepQ;
  assign dynamicSleepEn = dynQ;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence sWrGlobal;
    regWrEn && regAddr == ADDR_GLOBAL;
  endsequence

  sequence sWrDyn;
    regWrEn && regAddr == ADDR_DYN;
  endsequence

  sequence sQuietGlobal;
    !(regWrEn && regAddr == ADDR_GLOBAL);
  endsequence

  chk_range_write: assert property ( // [RULE_01]
    regWrEn && regAddr == ADDR_RANGE |=>
      ambientCancelRange == $past(regWdata[RANGE_MSB:RANGE_LSB]) ##1
      ambientRangeValid == pdc_range_ok($past(ambientCancelRange)))
    else $error("Ambient range field or validity wrong after write");

  chk_reserved_zero: assert property ( // [RULE_02]
    regRdEn |=> (regRdata & ~(RANGE_MASK | GLOBAL_MASK | DYN_MASK)) == 24'h000000)
    else $error("Reserved bits read back nonzero");

  chk_global_off: assert property ( // [RULE_03]
    sWrGlobal ##0 !regWdata[GLOBAL_BIT] ##1 sQuietGlobal |=> blockSleep == '0)
    else $error("Blocks asleep without global request");

  chk_keep_polarity: assert property ( // [RULE_04]
    sWrGlobal ##0 regWdata[GLOBAL_BIT] ##1 sQuietGlobal |=>
      blockSleep == (~$past(regWdata[BLOCK_N-1:0], 2) & BLOCK_MASK))
    else $error("Keep-awake polarity wrong");

  chk_osc_host: assert property ( // [RULE_05]
    globalSleepRequest && keepAwake[BIT_OSCILLATOR] && keepAwake[BIT_HOST_MASTER]
      |=> !blockSleep[BIT_OSCILLATOR] && !blockSleep[BIT_HOST_MASTER])
    else $error("Oscillator or host master slept while kept awake");

  chk_converter: assert property ( // [RULE_06]
    $past(globalSleepRequest) |-> blockSleep[6] == !$past(keepAwake[6]))
    else $error("Ambient converter sleep wrong");

  chk_amb_cancel: assert property ( // [RULE_07]
    $past(globalSleepRequest) |-> blockSleep[5] == !$past(keepAwake[5]))
    else $error("Ambient cancel sleep wrong");

  chk_frontend: assert property ( // [RULE_08]
    $past(globalSleepRequest) |->
      blockSleep[4:3] == ~$past(keepAwake[4:3]))
    else $error("Front end sleep wrong");

  chk_emitter: assert property ( // [RULE_09]
    $past(globalSleepRequest) && !$past(keepAwake[2]) |-> blockSleep[2])
    else $error("Emitter driver failed to sleep");

  chk_thermal: assert property ( // [RULE_10]
    $past(globalSleepRequest) && $past(keepAwake[1]) |-> !blockSleep[1])
    else $error("Thermal sensor slept while kept awake");

  chk_reference: assert property ( // [RULE_11]
    $past(globalSleepRequest) && !$past(keepAwake[0]) |-> blockSleep[0])
    else $error("Reference failed to sleep");

  chk_dyn_write: assert property ( // [RULE_12]
    sWrDyn |=> dynamicSleepEn == ($past(regWdata[BLOCK_N-1:0]) & BLOCK_MASK))
    else $error("Dynamic sleep enables not stored");

  chk_sleep_map: assert property ( // [RULE_13]
    ##1 blockSleep == ({BLOCK_N{$past(globalSleepRequest)}} & ~$past(keepAwake) & BLOCK_MASK))
    else $error("Block sleep does not follow request and keep bits");

  // ****************************************************************
  // Read path and hold checks
  // ****************************************************************
  sequence sRead;
    regRdEn;
  endsequence

  sequence sWrRange;
    regWrEn && regAddr == ADDR_RANGE;
  endsequence

  sequence sUnmapped;
    regAddr != ADDR_RANGE && regAddr != ADDR_GLOBAL && regAddr != ADDR_DYN;
  endsequence

  chk_read_pulse: assert property ( // [RULE_02]
    sRead |=> regRdValid)
    else $error("Read strobe gave no valid pulse");

  chk_valid_drop: assert property ( // [RULE_02]
    !regRdEn |=> !regRdValid)
    else $error("Read valid without a read strobe");

  chk_read_range: assert property ( // [RULE_01]
    sRead ##0 regAddr == ADDR_RANGE |=>
      regRdata[RANGE_MSB:RANGE_LSB] == $past(ambientCancelRange))
    else $error("Range read data wrong");

  chk_read_global: assert property ( // [RULE_03]
    sRead ##0 regAddr == ADDR_GLOBAL |=>
      regRdata[GLOBAL_BIT] == $past(globalSleepRequest) &&
      regRdata[BLOCK_N-1:0] == $past(keepAwake))
    else $error("Global control read data wrong");

  chk_read_dyn: assert property ( // [RULE_12]
    sRead ##0 regAddr == ADDR_DYN |=> regRdata == DATA_W'($past(dynamicSleepEn)))
    else $error("Dynamic sleep read data wrong");

  chk_unmapped_read: assert property ( // [RULE_02]
    sRead ##0 sUnmapped |=> regRdata == '0)
    else $error("Unmapped read returned nonzero");

  chk_keep_hold: assert property ( // [RULE_04]
    sQuietGlobal |=> $stable(keepAwake) && $stable(globalSleepRequest))
    else $error("Keep bits changed without a write");

  chk_range_hold: assert property ( // [RULE_01]
    !regWrEn || regAddr != ADDR_RANGE |=> $stable(ambientCancelRange))
    else $error("Range changed without a write");

  chk_dyn_hold: assert property ( // [RULE_12]
    !regWrEn || regAddr != ADDR_DYN |=> $stable(dynamicSleepEn))
    else $error("Dynamic enables changed without a write");

  chk_reserved_keep: assert property ( // [RULE_02]
    sWrRange or sWrGlobal or sWrDyn |=> !keepAwake[7] && !dynamicSleepEn[7])
    else $error("Reserved block bit stored");

endmodule

`default_nettype wire

/* verif/pdc_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pdc_regs_bench;
  import pdc_pkg::*;
  logic clock, arst_n, regWrEn, regRdEn;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata;
  logic regRdValid, ambientRangeValid, globalSleepRequest;
  logic [3:0] ambientCancelRange;
  logic [BLOCK_N-1:0] keepAwake, blockSleep, dynamicSleepEn;
  logic [23:0] rngQ, glbQ, dynQ, v;
  logic [7:0] addrs [4];
  int badCount, nCompared, i;

  pdc_regs u_dut (.clock(clock), .arst_n(arst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .ambientCancelRange(ambientCancelRange), .ambientRangeValid(ambientRangeValid),
    .globalSleepRequest(globalSleepRequest), .keepAwake(keepAwake),
    .blockSleep(blockSleep), .dynamicSleepEn(dynamicSleepEn));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ****************************************************************
  // Expectations
  // ****************************************************************
  function automatic logic [23:0] expRead(input logic [7:0] a);
    case (a)
      8'h72: return rngQ;
      8'h76: return glbQ;
      8'h77: return dynQ;
      default: return 24'h000000;
    endcase
  endfunction
  function automatic logic codeOk(input logic [3:0] c);
    return c == 4'h0 || c == 4'h5 || c == 4'ha || c == 4'hb || c == 4'hc || c == 4'he;
  endfunction
  function automatic logic [9:0] expSleep();
    return glbQ[11] ? (~glbQ[9:0] & 10'h37f) : 10'h000;
  endfunction

  // ****************************************************************
  // Port tasks
  // ****************************************************************
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic store(input logic [7:0] a, input logic [23:0] d);
    if (a == 8'h72) rngQ = d & 24'h0000f0;
    if (a == 8'h76) glbQ = d & 24'h000b7f;
    if (a == 8'h77) dynQ = d & 24'h00037f;
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clock);
    #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge clock);
    #1;
    regWrEn = 1'b0;
    store(a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge clock);
    #1;
    regRdEn = 1'b0;
    check(24'(regRdValid), 24'h000001);
    check(regRdata, expRead(a));
  endtask
  task automatic checkAll();
    @(posedge clock);
    #1;
    check(24'(ambientCancelRange), 24'(rngQ[7:4]));
    check(24'(ambientRangeValid), 24'(codeOk(rngQ[7:4])));
    check(24'(globalSleepRequest), 24'(glbQ[11]));
    check(24'(keepAwake), 24'(glbQ[9:0]));
    check(24'(blockSleep), 24'(expSleep()));
    check(24'(dynamicSleepEn), 24'(dynQ[9:0]));
    for (int k = 0; k < 4; k++) rd(addrs[k]);
  endtask
  task automatic doReset();
    arst_n = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    arst_n = 1'b1;
    rngQ = 24'h0000c0;
    glbQ = 24'h000000;
    dynQ = 24'h000000;
  endtask
  task automatic tallyAndFinish();
    $display("compared %0d, mismatched %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    arst_n = 1'b0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWdata = 24'h000000;
    badCount = 0;
    nCompared = 0;
    addrs = '{8'h72, 8'h76, 8'h77, 8'h75};
    void'($urandom(32'haf73d134));
    doReset();
    checkAll();
    $display("reset values done");
    for (i = 0; i < 16; i++) begin
      wr(8'h72, (24'(i) << 4) | 24'hffff0f);
      checkAll();
    end
    $display("range codes done");
    for (i = 0; i < 10; i++) begin
      wr(8'h76, 24'h000800 | (24'h000001 << i));
      checkAll();
      wr(8'h77, 24'h000001 << i);
      checkAll();
    end
    $display("block bits done");
    for (i = 0; i < 40; i++) begin
      regAddr = ($urandom % 5 == 4) ? 8'($urandom) : addrs[$urandom % 3];
      wr(regAddr, 24'($urandom));
      checkAll();
    end
    $display("random traffic done");
    v = dynQ;
    @(posedge clock);
    #1;
    regWrEn = 1'b1;
    regRdEn = 1'b1;
    regAddr = 8'h77;
    regWdata = ~v;
    @(posedge clock);
    #1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    check(regRdata, v);
    store(8'h77, ~v);
    checkAll();
    $display("read during write done");
    wr(8'h76, 24'h000800);
    doReset();
    checkAll();
    $display("second reset done");
    tallyAndFinish();
  end
endmodule
`default_nettype wire
